// file: common/alert_ctl_defs.svh
// Purpose: Register offsets, field positions, reset values and timing
//          constants of the alert masking and throttle timer block.
// Assumes: Byte-wide registers reached through the serial register port.
// Notes:   Only definitions live here.
`ifndef ALERT_CTL_DEFS_SVH
`define ALERT_CTL_DEFS_SVH

// Register offsets
`define OFS_STATUS_ONE      8'h41
`define OFS_STATUS_TWO      8'h42
`define OFS_MASK_ONE        8'h74
`define OFS_MASK_TWO        8'h75
`define OFS_CONFIG_THREE    8'h78
`define OFS_THROTTLE_TIME   8'h79
`define OFS_THROTTLE_LIMIT  8'h7A
`define OFS_CONFIG_FOUR     8'h7D

// Field positions
`define CFG3_ALERT_SEL_BIT  0
`define CFG3_THR_EN_BIT     1
`define CFG3_FULL_DUTY_ON_THROTTLE_BIT      2
`define STAT_ONE_THR_BIT    0
`define STAT_TWO_F4_BIT     5
`define MASK_ONE_SUM_BIT    7

// Reset values and timer full scale
`define RST_MASK            8'h00
`define RST_CONFIG          8'h00
`define RST_LIMIT           8'h00
`define RST_TIMER           8'h00
`define TIMER_FULL          8'hFF

// Timing
`define CLK_PERIOD_NS       10
`define THR_TICK_US         22760
`define THR_TICK_CYCLES     (`THR_TICK_US * 1000 / `CLK_PERIOD_NS)

`endif

// file: common/alert_ctl_pkg.sv
// Purpose: Types shared by the alert masking and throttle timer block.
// Assumes: Constants come from alert_ctl_defs.svh.
// Notes:   One-hot serial port states and the multi-function pin choice.
package alert_ctl_pkg;

   // Serial register port states
   typedef enum logic [7:0] {
      S_IDLE  = 8'b0000_0001,
      S_ADDR  = 8'b0000_0010,
      S_AACK  = 8'b0000_0100,
      S_CMD   = 8'b0000_1000,
      S_CACK  = 8'b0001_0000,
      S_WDATA = 8'b0010_0000,
      S_WACK  = 8'b0100_0000,
      S_RDATA = 8'b1000_0000
   } port_state_t;

   // Multi-function pin selection, written as {bit1, bit0}
   typedef enum logic [1:0] {
      P14_TACH  = 2'b00,
      P14_ALERT = 2'b01,
      P14_THR   = 2'b10,
      P14_GPIO  = 2'b11
   } pin14_func_t;

endpackage

// file: design/throttle_timer.sv
// Purpose: Cumulative, saturating assertion timer for the throttle line.
// Assumes: asserted is synchronous to clk_sys; clear_rd is a one-cycle pulse.
// Notes:   Resolution is one tick; the first assertion shows as a count of one.
`timescale 1ns/10ps
`include "alert_ctl_defs.svh"
module throttle_timer #(
   parameter int unsigned TICK_CYCLES = `THR_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Control
   input  wire logic       asserted,
   input  wire logic       clear_rd,
   // Result
   output logic [7:0]      value
);
   logic [31:0] presc;
   logic [7:0]  ticks;
   logic        started;
   wire         tick_end = (presc == 32'(TICK_CYCLES - 1));
   wire         at_full  = (ticks == `TIMER_FULL);

   // Accumulate only while asserted, saturate, clear on read
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         presc   <= 32'h0000_0000;
         ticks   <= `RST_TIMER;
         started <= 1'b0;
      end else if (clear_rd) begin
         presc   <= 32'h0000_0000;
         ticks   <= `RST_TIMER;
         started <= asserted;
      end else if (asserted && !at_full) begin
         started <= 1'b1;
         presc   <= tick_end ? 32'h0000_0000 : presc + 32'h0000_0001;
         if (tick_end)
            ticks <= ticks + 8'h01;
      end else if (asserted) begin
         started <= 1'b1;
      end
   end

   // First assertion reads as one until two ticks have passed
   assign value = (started && ticks == 8'h00) ? 8'h01 : ticks;

   AST_TIMER_SATURATES: assert property (@(posedge clk_sys) disable iff (reset)
      value == 8'hFF && !clear_rd |=> value == 8'hFF)
      else $error("timer left full scale without a read");
   AST_TIMER_PAUSES: assert property (@(posedge clk_sys) disable iff (reset)
      !asserted && !clear_rd |=> $stable(value))
      else $error("timer moved while throttle line idle");
   AST_READ_CLEARS: assert property (@(posedge clk_sys) disable iff (reset)
      clear_rd && !asserted |=> value == 8'h00)
      else $error("timer not cleared by read");
   AST_READ_DURING_ASSERT: assert property (@(posedge clk_sys) disable iff (reset)
      clear_rd && asserted |=> value == 8'h01)
      else $error("timer did not restart at one");
endmodule // throttle_timer

// file: design/alert_mask_and_throttle_timer.sv
// Purpose: Alert masking, pin assignment and throttle timing with its
//          serial register port.
// Assumes: Limit comparators, fan control and PWM live outside this block.
// Notes:   Serial port and pins are sampled through two flip-flops.
// Summary of operation
// - Mask gates alert only, status still sets
// - Mask one bits: summary, temps, supplies, throttle
// - Mask two bits: diodes, fans, overtemperature
// - Mask two bit0 covers twelve volt/code change
// - Mask two bit5 covers throttle or GPIO
// - Pin 10 alert when selected, else PWM
// - Pin 14 function from config four bits
// - Throttle enable makes pin 22 throttle line
// - Pin 14 throttle off without throttle enable
// - Full_duty_on_throttle drives running fans full while throttled
// - Full_duty_on_throttle ignored for fans not running
// - Timer counts only during assertion, cumulative
// - Timer saturates at full scale
// - First assertion bit0, then tick LSB
// - Timer register cleared by read
// - Read during assertion restarts at one
// - Limit zero read during assertion sets flag again
// - Status sticky until read after condition ends
// - Alert held while unmasked status stays set
// - Timer above limit sets flag, alerts
`timescale 1ns/10ps
`include "alert_ctl_defs.svh"
module alert_mask_and_throttle_timer
   import alert_ctl_pkg::*;
#(
   parameter logic [6:0]  SLAVE_ADDR  = 7'h2E,  // Arbitrary default
   parameter int unsigned TICK_CYCLES = `THR_TICK_CYCLES
) (
   // Clock and reset
   input  wire logic       clk_sys,
   input  wire logic       reset,
   // Serial register port, open drain data
   input  wire logic       smb_clk,
   input  wire logic       smb_data_in,
   output logic            smb_data_out,
   output logic            smb_data_oe,
   // Out-of-limit sources from the comparators
   input  wire logic [6:0] limit_one,
   input  wire logic [7:0] limit_two,
   input  wire logic       general_io_six_event,
   // Multi-function pins
   input  wire logic       pin22_in,
   input  wire logic       pin14_in,
   output logic            pin14_out,
   output logic            pin14_oe,
   output logic            fan_four_tach,
   input  wire logic       second_fan_drive,
   output logic            pin10_out,
   // Fan full_duty_on_throttle
   input  wire logic [3:0] fan_running,
   output logic [3:0]      full_duty_on_throttle
);
   // Pin synchronisers: smb_clk, smb_data_in, pin22_in, pin14_in
   logic [3:0] sync_a;
   logic [3:0] sync_b;
   logic [1:0] prev_bus;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         sync_a   <= 4'hF;
         sync_b   <= 4'hF;
         prev_bus <= 2'b11;
      end else begin
         sync_a   <= {pin14_in, pin22_in, smb_data_in, smb_clk};
         sync_b   <= sync_a;
         prev_bus <= sync_b[1:0];
      end
   end

   // Edge and framing decode on the second stage only
   wire scl_s     = sync_b[0];
   wire sda_s     = sync_b[1];
   wire pin22_s   = sync_b[2];
   wire pin14_s   = sync_b[3];
   wire scl_rise  = scl_s & ~prev_bus[0];
   wire scl_fall  = ~scl_s & prev_bus[0];
   wire start_det = scl_s & prev_bus[0] & prev_bus[1] & ~sda_s;
   wire stop_det  = scl_s & prev_bus[0] & ~prev_bus[1] & sda_s;

   // Port state
   port_state_t st;
   logic [3:0]  bitcnt;
   logic [7:0]  sh;
   logic [7:0]  ptr;
   logic        rw;
   logic        nack;
   logic        sda_oe;
   logic [7:0]  rd_data;

   wire byte_done = (bitcnt == 4'd8);
   wire st_rx     = (st == S_ADDR) | (st == S_CMD) | (st == S_WDATA);
   wire quiet     = ~start_det & ~stop_det;
   wire wr_stb    = quiet & scl_fall & (st == S_WDATA) & byte_done;
   wire rd_stb    = quiet & scl_fall & (((st == S_AACK) & rw)
                    | ((st == S_RDATA) & (bitcnt == 4'd9) & ~nack));

   // Byte engine: sample on clock rise, drive on clock fall
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         st     <= S_IDLE;
         bitcnt <= 4'd0;
         sh     <= 8'h00;
         ptr    <= 8'h00;
         rw     <= 1'b0;
         nack   <= 1'b0;
         sda_oe <= 1'b0;
      end else if (start_det) begin
         st     <= S_ADDR;
         bitcnt <= 4'd0;
         sda_oe <= 1'b0;
      end else if (stop_det) begin
         st     <= S_IDLE;
         sda_oe <= 1'b0;
      end else if (scl_rise) begin
         bitcnt <= bitcnt + 4'd1;
         if (st_rx)
            sh <= {sh[6:0], sda_s};
         if (st == S_RDATA && byte_done)
            nack <= sda_s;
      end else if (scl_fall) begin
         case (st)
            S_ADDR: begin
               if (byte_done && sh[7:1] == SLAVE_ADDR) begin
                  sda_oe <= 1'b1;
                  rw     <= sh[0];
                  st     <= S_AACK;
               end else if (byte_done) begin
                  st <= S_IDLE;
               end
            end
            S_AACK: begin
               bitcnt <= 4'd0;
               if (rw) begin
                  sh     <= rd_data;
                  sda_oe <= ~rd_data[7];
                  st     <= S_RDATA;
               end else begin
                  sda_oe <= 1'b0;
                  st     <= S_CMD;
               end
            end
            S_CMD: begin
               if (byte_done) begin
                  ptr    <= sh;
                  sda_oe <= 1'b1;
                  st     <= S_CACK;
               end
            end
            S_CACK, S_WACK: begin
               bitcnt <= 4'd0;
               sda_oe <= 1'b0;
               st     <= S_WDATA;
            end
            S_WDATA: begin
               if (byte_done) begin
                  sda_oe <= 1'b1;
                  st     <= S_WACK;
               end
            end
            S_RDATA: begin
               if (bitcnt < 4'd8) begin
                  sda_oe <= ~sh[3'd7 - bitcnt[2:0]];
               end else if (byte_done) begin
                  sda_oe <= 1'b0;
               end else if (nack) begin
                  st <= S_IDLE;
               end else begin
                  bitcnt <= 4'd0;
                  sh     <= rd_data;
                  sda_oe <= ~rd_data[7];
               end
            end
            default: st <= S_IDLE;
         endcase
      end
   end

   // Register address match, shared by reads and writes
   function automatic logic hit(input logic [7:0] p, input logic [7:0] ofs);
      hit = (p == ofs);
   endfunction

   // Software registers
   logic [7:0] mask_one;
   logic [7:0] mask_two;
   logic [7:0] cfg_three;
   logic [7:0] cfg_four;
   logic [7:0] thr_limit;
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         mask_one  <= `RST_MASK;
         mask_two  <= `RST_MASK;
         cfg_three <= `RST_CONFIG;
         cfg_four  <= `RST_CONFIG;
         thr_limit <= `RST_LIMIT;
      end else if (wr_stb) begin
         if (hit(ptr, `OFS_MASK_ONE))       mask_one  <= sh;
         if (hit(ptr, `OFS_MASK_TWO))       mask_two  <= sh;
         if (hit(ptr, `OFS_CONFIG_THREE))   cfg_three <= sh;
         if (hit(ptr, `OFS_CONFIG_FOUR))    cfg_four  <= sh;
         if (hit(ptr, `OFS_THROTTLE_LIMIT)) thr_limit <= sh;
      end
   end

   // Pin roles and throttle line
   pin14_func_t p14_func;
   assign p14_func = pin14_func_t'(cfg_four[1:0]);
   wire thr_en     = cfg_three[`CFG3_THR_EN_BIT];
   wire p14_thr    = thr_en & (p14_func == P14_THR);
   wire throttle   = thr_en & (~pin22_s | (p14_thr & ~pin14_s));
   wire full_duty_on_throttle_on   = cfg_three[`CFG3_FULL_DUTY_ON_THROTTLE_BIT] & throttle;

   // Throttle timer
   logic [7:0] timer_value;
   wire        rd_timer = rd_stb & hit(ptr, `OFS_THROTTLE_TIME);
   throttle_timer #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_timer (
      .clk_sys  (clk_sys),
      .reset    (reset),
      .asserted (throttle),
      .clear_rd (rd_timer),
      .value    (timer_value)
   );

   // Limit exceeded; with limit zero the restart value of one re-flags
   wire timer_over = thr_en & (timer_value > thr_limit);

   // Status sources; timer over limit always raises status two bit 5,
   // and also status one bit 0 when pin 22 alone carries the line
   logic [6:0] src_one;
   logic [7:0] src_two;
   always_comb begin
      src_one = limit_one;
      src_two = limit_two;
      if (thr_en && !p14_thr)
         src_one[`STAT_ONE_THR_BIT] = timer_over;
      case (p14_func)
         P14_THR:  src_two[`STAT_TWO_F4_BIT] = timer_over;
         P14_GPIO: src_two[`STAT_TWO_F4_BIT] = general_io_six_event | timer_over;
         default:  src_two[`STAT_TWO_F4_BIT] = limit_two[`STAT_TWO_F4_BIT] | timer_over;
      endcase
   end

   // Sticky status: set wins, read clears only once the source is gone
   logic [6:0] stat_one;
   logic [7:0] stat_two;
   wire rd_one = rd_stb & hit(ptr, `OFS_STATUS_ONE);
   wire rd_two = rd_stb & hit(ptr, `OFS_STATUS_TWO);
   wire [6:0] next_stat_one = src_one | (rd_one ? 7'h00 : stat_one);
   wire [7:0] next_stat_two = src_two | (rd_two ? 8'h00 : stat_two);
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         stat_one <= 7'h00;
         stat_two <= 8'h00;
      end else begin
         stat_one <= next_stat_one;
         stat_two <= next_stat_two;
      end
   end

   // Alert: any unmasked status bit; summary bit gates the second register
   wire sum_two   = |stat_two;
   wire alert_one = |(stat_one & ~mask_one[6:0]);
   wire alert_two = ~mask_one[`MASK_ONE_SUM_BIT] & |(stat_two & ~mask_two);
   wire alert_any = alert_one | alert_two;

   // Read data selection
   always_comb begin
      case (ptr)
         `OFS_STATUS_ONE:     rd_data = {sum_two, stat_one};
         `OFS_STATUS_TWO:     rd_data = stat_two;
         `OFS_MASK_ONE:       rd_data = mask_one;
         `OFS_MASK_TWO:       rd_data = mask_two;
         `OFS_CONFIG_THREE:   rd_data = cfg_three;
         `OFS_THROTTLE_TIME:  rd_data = timer_value;
         `OFS_THROTTLE_LIMIT: rd_data = thr_limit;
         `OFS_CONFIG_FOUR:    rd_data = cfg_four;
         default:             rd_data = 8'h00;
      endcase
   end

   // Registered pin drive; pin 10 is push-pull, pin 14 open drain
   always_ff @(posedge clk_sys) begin
      if (reset) begin
         smb_data_out          <= 1'b0;
         smb_data_oe           <= 1'b0;
         pin10_out             <= 1'b0;
         pin14_out             <= 1'b0;
         pin14_oe              <= 1'b0;
         fan_four_tach         <= 1'b1;
         full_duty_on_throttle <= 4'h0;
      end else begin
         smb_data_out          <= 1'b0;
         smb_data_oe           <= sda_oe;
         pin10_out             <= cfg_three[`CFG3_ALERT_SEL_BIT] ? ~alert_any
                                  : second_fan_drive;
         pin14_out             <= 1'b0;
         pin14_oe              <= (p14_func == P14_ALERT) & alert_any;
         fan_four_tach         <= (p14_func == P14_TACH) ? pin14_s : 1'b1;
         full_duty_on_throttle <= {4{full_duty_on_throttle_on}} & fan_running;
      end
   end

   AST_MASK_KEEPS_STATUS: assert property (@(posedge clk_sys) disable iff (reset)
      limit_one[6] && mask_one[6] |=> stat_one[6])
      else $error("masked source did not set status");
   AST_STICKY_UNTIL_READ: assert property (@(posedge clk_sys) disable iff (reset)
      stat_two[7] && !rd_two |=> stat_two[7])
      else $error("status bit dropped without a read");
   AST_PIN10_ALERT: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_three[`CFG3_ALERT_SEL_BIT] && (stat_one[6] && !mask_one[6]) |=> !pin10_out)
      else $error("pin 10 alert not low for unmasked status");
   AST_PIN10_PWM: assert property (@(posedge clk_sys) disable iff (reset)
      !cfg_three[`CFG3_ALERT_SEL_BIT] |=> pin10_out == $past(second_fan_drive))
      else $error("pin 10 not carrying fan drive");
   AST_PIN14_ALERT: assert property (@(posedge clk_sys) disable iff (reset)
      cfg_four[1:0] == 2'b01 && alert_any |=> pin14_oe && !pin14_out)
      else $error("pin 14 alert not driven");
   AST_MASK_BLOCKS: assert property (@(posedge clk_sys) disable iff (reset)
      (stat_one & ~mask_one[6:0]) == 7'h00 && mask_one[7] |-> !alert_any)
      else $error("alert raised by masked sources only");
   AST_THR_DISABLED: assert property (@(posedge clk_sys) disable iff (reset)
      !cfg_three[`CFG3_THR_EN_BIT] |-> !throttle)
      else $error("throttle active while disabled");
   AST_FULL_DUTY_ON_THROTTLE: assert property (@(posedge clk_sys) disable iff (reset)
      throttle && cfg_three[`CFG3_FULL_DUTY_ON_THROTTLE_BIT] && fan_running[0] |=> full_duty_on_throttle[0])
      else $error("running fan not boosted");
   AST_FULL_DUTY_ON_THROTTLE_IDLE_FAN: assert property (@(posedge clk_sys) disable iff (reset)
      !fan_running[1] |=> !full_duty_on_throttle[1])
      else $error("stopped fan boosted");
   AST_TIMER_FLAG: assert property (@(posedge clk_sys) disable iff (reset)
      p14_thr && timer_value > thr_limit |=> stat_two[`STAT_TWO_F4_BIT])
      else $error("timer over limit did not flag");
endmodule // alert_mask_and_throttle_timer

// file: tb/smb_host_model.sv
// Purpose: Behavioural serial bus host that reads and writes device registers.
// Assumes: Data wire has a pull-up; clock stands high between frames.
// Notes:   Fixed 125 ns bit time, data changed a quarter bit after the fall.
`timescale 1ns/10ps
module smb_host_model #(
   parameter real Q = 31.25
) (
   // Bus wires
   output logic      smb_clk,
   output wire logic smb_data_in,
   // Device pull-down
   input  wire logic smb_data_oe
);
   logic pull = 1'b0;

   // Wired-AND: low while either party pulls, pull-up level otherwise
   assign smb_data_in = ~(pull | smb_data_oe);
   initial smb_clk = 1'b1;

   // One bit; data set in the low phase so the device never sees it move while high
   task automatic bit_io(input logic b, output logic s);
      #Q pull = ~b;
      #Q smb_clk = 1'b1;
      #Q s = smb_data_in;
      #Q smb_clk = 1'b0;
   endtask

   // Start or repeated start: data falls while clock high
   task automatic start_cond;
      #Q pull = 1'b0;
      #Q smb_clk = 1'b1;
      #Q pull = 1'b1;
      #Q smb_clk = 1'b0;
   endtask

   // Stop: data rises while clock high, then bus left idle
   task automatic stop_cond;
      #Q pull = 1'b1;
      #Q smb_clk = 1'b1;
      #Q pull = 1'b0;
      #Q;
   endtask

   // Byte MSB first; ninth bit released, so host reads ack or sends NACK
   task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(tx[i], s);
         rx[i] = s;
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask

   task automatic wr(input logic [6:0] dev, input logic [7:0] cmd, input logic [7:0] dat,
                     output logic ok);
      logic [7:0] rx;
      logic       a1, a2, a3;
      start_cond();
      byte_io({dev, 1'b0}, rx, a1);
      byte_io(cmd, rx, a2);
      byte_io(dat, rx, a3);
      stop_cond();
      ok = a1 & a2 & a3;
   endtask

   task automatic rd(input logic [6:0] dev, input logic [7:0] cmd, output logic [7:0] dat,
                     output logic ok);
      logic [7:0] rx;
      logic       a1, a2, a3, a4;
      start_cond();
      byte_io({dev, 1'b0}, rx, a1);
      byte_io(cmd, rx, a2);
      start_cond();
      byte_io({dev, 1'b1}, rx, a3);
      byte_io(8'hFF, dat, a4);
      stop_cond();
      ok = a1 & a2 & a3;
   endtask
endmodule // smb_host_model

// file: tb/alert_mask_and_throttle_timer_test.sv
// Purpose: Self-checking bench for alert masking, pin choice and throttle timer.
// Assumes: Host model on the serial port; short timer tick for run length.
// Notes:   Sources are pulsed so status stickiness shows after they clear.
`timescale 1ns/10ps
`include "alert_ctl_defs.svh"
module alert_mask_and_throttle_timer_test;
   localparam int unsigned TICK = 150;
   localparam logic [6:0]  DEV  = 7'h2E;
   logic       clk_sys, reset, smb_data_oe, pin14_oe, fan_four_tach, pin10_out;
   logic       smb_data_out, pin14_out;
   wire        smb_clk, smb_data_in;
   logic [6:0] limit_one;
   logic [7:0] limit_two, rd_val;
   logic       general_io_six_event, pin22_in, pin14_in, second_fan_drive, bus_ok;
   logic [3:0] fan_running, full_duty_on_throttle;
   int         fails, cmp_count;

   alert_mask_and_throttle_timer #(.SLAVE_ADDR(DEV), .TICK_CYCLES(TICK)) u_dut (
      .clk_sys(clk_sys), .reset(reset), .smb_clk(smb_clk), .smb_data_in(smb_data_in),
      .smb_data_out(smb_data_out), .smb_data_oe(smb_data_oe), .limit_one(limit_one),
      .limit_two(limit_two), .general_io_six_event(general_io_six_event),
      .pin22_in(pin22_in), .pin14_in(pin14_in), .pin14_out(pin14_out), .pin14_oe(pin14_oe),
      .fan_four_tach(fan_four_tach), .second_fan_drive(second_fan_drive),
      .pin10_out(pin10_out), .fan_running(fan_running),
      .full_duty_on_throttle(full_duty_on_throttle));

   smb_host_model u_host (.smb_clk(smb_clk), .smb_data_in(smb_data_in),
                          .smb_data_oe(smb_data_oe));

   // 100 MHz system clock
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys);
   endtask

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("[ERR] %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [7:0] cmd, input logic [7:0] dat);
      u_host.wr(DEV, cmd, dat, bus_ok);
   endtask

   task automatic rdchk(input logic [7:0] cmd, input logic [7:0] exp);
      u_host.rd(DEV, cmd, rd_val, bus_ok);
      chk(rd_val, exp);
   endtask

   // Pin 10 level after the one-cycle output register has settled
   task automatic alert_is(input logic exp);
      cyc(3);
      #1;
      chk({7'h00, pin10_out}, {7'h00, exp});
   endtask

   // Sources high for a few cycles, then gone, so only sticky status remains
   task automatic pulse(input logic [6:0] l1, input logic [7:0] l2, input logic g);
      @(posedge clk_sys);
      limit_one <= l1;
      limit_two <= l2;
      general_io_six_event <= g;
      cyc(4);
      limit_one <= 7'h00;
      limit_two <= 8'h00;
      general_io_six_event <= 1'b0;
      cyc(6);
   endtask

   task automatic thr(input int n);
      @(posedge clk_sys);
      pin22_in <= 1'b0;
      cyc(n);
      pin22_in <= 1'b1;
      cyc(4);
   endtask

   task automatic give_verdict;
      if (fails == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // Hang guard, well beyond the longest sequence
   initial begin
      cyc(90000);
      fails++;
      give_verdict();
   end

   // Main sequence
   initial begin
      logic [7:0] bitk, full;
      reset = 1'b1;
      limit_one = 7'h00;
      limit_two = 8'h00;
      general_io_six_event = 1'b0;
      pin22_in = 1'b1;
      pin14_in = 1'b1;
      second_fan_drive = 1'b0;
      fan_running = 4'hF;
      fails = 0;
      cmp_count = 0;
      cyc(10);
      reset <= 1'b0;
      second_fan_drive <= 1'b1;
      cyc(5);
      alert_is(1'b1);
      chk({7'h00, pin14_oe}, 8'h00);
      rdchk(`OFS_MASK_ONE, 8'h00);
      rdchk(`OFS_MASK_TWO, 8'h00);
      wr(`OFS_MASK_ONE, 8'hA5);
      u_host.wr(7'h2F, `OFS_MASK_ONE, 8'hFF, bus_ok);
      chk({7'h00, bus_ok}, 8'h00);
      rdchk(`OFS_MASK_ONE, 8'hA5);
      rdchk(8'h50, 8'h00);
      wr(`OFS_CONFIG_THREE, 8'h01);
      cyc(1);
      second_fan_drive <= 1'b0;
      alert_is(1'b1);
      // Each mask bit alone unmasked: others blocked, its own source alerts
      for (int r = 0; r < 2; r++) begin
         wr(`OFS_MASK_ONE, r ? 8'h7F : 8'h00);
         full = r ? 8'hFF : 8'h7F;
         for (int k = 0; k < 7 + r; k++) begin
            bitk = 8'h01 << k;
            wr(r ? `OFS_MASK_TWO : `OFS_MASK_ONE, ~bitk);
            pulse(r ? 7'h00 : full[6:0] & ~bitk[6:0], r ? full & ~bitk : 8'h00, 1'b0);
            alert_is(1'b1);
            pulse(r ? 7'h00 : bitk[6:0], r ? bitk : 8'h00, 1'b0);
            alert_is(1'b0);
            rdchk(r ? `OFS_STATUS_TWO : `OFS_STATUS_ONE, full);
            alert_is(1'b1);
         end
      end
      wr(`OFS_MASK_ONE, 8'hFF);
      wr(`OFS_MASK_TWO, 8'h00);
      pulse(7'h00, 8'h01, 1'b0);
      alert_is(1'b1);
      rdchk(`OFS_STATUS_TWO, 8'h01);
      // General-purpose pin as status source behind mask two bit 5
      wr(`OFS_CONFIG_FOUR, 8'h03);
      wr(`OFS_MASK_ONE, 8'h7F);
      wr(`OFS_MASK_TWO, 8'h20);
      pulse(7'h00, 8'h00, 1'b1);
      alert_is(1'b1);
      wr(`OFS_MASK_TWO, 8'h00);
      alert_is(1'b0);
      rdchk(`OFS_STATUS_TWO, 8'h20);
      // Pin 14 modes with an alert pending and pin 14 held low
      pulse(7'h00, 8'h02, 1'b0);
      pin14_in <= 1'b0;
      wr(`OFS_CONFIG_THREE, 8'h05);
      for (int m = 0; m < 4; m++) begin
         wr(`OFS_CONFIG_FOUR, m[7:0]);
         cyc(4);
         chk({4'h0, smb_data_out, pin14_out, pin14_oe, fan_four_tach},
             m == 1 ? 8'h03 : (m == 0 ? 8'h00 : 8'h01));
         chk({4'h0, full_duty_on_throttle}, 8'h00);
      end
      wr(`OFS_CONFIG_FOUR, 8'h02);
      wr(`OFS_CONFIG_THREE, 8'h07);
      cyc(4);
      chk({4'h0, full_duty_on_throttle}, 8'h0F);
      fan_running <= 4'h5;
      cyc(3);
      chk({4'h0, full_duty_on_throttle}, 8'h05);
      pin14_in <= 1'b1;
      fan_running <= 4'hF;
      cyc(4);
      chk({4'h0, full_duty_on_throttle}, 8'h00);
      wr(`OFS_CONFIG_FOUR, 8'h00);
      u_host.rd(DEV, `OFS_THROTTLE_TIME, rd_val, bus_ok);
      u_host.rd(DEV, `OFS_STATUS_ONE, rd_val, bus_ok);
      u_host.rd(DEV, `OFS_STATUS_TWO, rd_val, bus_ok);
      // Pin 22 ignored while throttle timing is disabled
      wr(`OFS_CONFIG_THREE, 8'h01);
      thr(3 * TICK);
      rdchk(`OFS_THROTTLE_TIME, 8'h00);
      // Timer resolution, accumulation, limit flag and clear-on-read
      wr(`OFS_THROTTLE_LIMIT, 8'h02);
      wr(`OFS_CONFIG_THREE, 8'h03);
      thr(TICK + 50);
      rdchk(`OFS_THROTTLE_TIME, 8'h01);
      rdchk(`OFS_THROTTLE_TIME, 8'h00);
      thr(3 * TICK);
      cyc(2 * TICK);
      thr(2 * TICK + 50);
      alert_is(1'b0);
      rdchk(`OFS_THROTTLE_TIME, 8'h05);
      rdchk(`OFS_STATUS_ONE, 8'h81);
      rdchk(`OFS_STATUS_TWO, 8'h20);
      rdchk(`OFS_STATUS_ONE, 8'h00);
      // Saturation, then a read while the line is still asserted
      wr(`OFS_THROTTLE_LIMIT, 8'h00);
      @(posedge clk_sys);
      pin22_in <= 1'b0;
      cyc(257 * TICK);
      rdchk(`OFS_THROTTLE_TIME, 8'hFF);
      pin22_in <= 1'b1;
      cyc(4);
      rdchk(`OFS_THROTTLE_TIME, 8'h01);
      rdchk(`OFS_STATUS_ONE, 8'h81);
      rdchk(`OFS_STATUS_TWO, 8'h20);
      rdchk(`OFS_STATUS_ONE, 8'h00);
      give_verdict();
   end
endmodule // alert_mask_and_throttle_timer_test
